// ---- verilog/adc_dsp_chain_config.sv ----
// recording-path dsp configuration registers and per-sample processing chain
`default_nettype none

module adc_dsp_chain_config (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_en_in,
	output logic [7:0] reg_rdata_out,
	// settings held in other registers
	input wire logic [7:0] first_channel_volume_in,
	input wire logic [7:0] second_channel_volume_in,
	input wire logic [1:0] channel_active_in,
	input wire logic [1:0] per_channel_setup_agc_in,
	// samples from the modulators
	input wire logic sample_valid_in,
	input wire logic signed [23:0] ch1_sample_in,
	input wire logic signed [23:0] ch2_sample_in,
	// samples to the serial audio interface
	output logic sample_valid_out,
	output logic signed [23:0] ch1_sample_out,
	output logic signed [23:0] ch2_sample_out,
	// configuration seen by the rest of the chain
	output logic [1:0] biquad_count_out,
	output logic [1:0] agc_active_out,
	output logic [5:0] auto_gain_target_db_out,
	output logic [5:0] auto_gain_ceiling_db_out
);
	logic [7:0] filter_select_config_reg;
	logic [7:0] volume_biquad_config_reg;
	logic [7:0] auto_gain_level_config_reg;
	logic [1:0] decimation_response_sel;
	logic [1:0] channel_sum_sel;
	logic [1:0] highpass_sel;
	logic volume_link;
	logic soft_step_off;
	logic auto_gain_master_en;
	logic [3:0] auto_gain_target;
	logic [3:0] auto_gain_ceiling;
	logic [3:0] ceiling_code;
	logic signed [24:0] avg_sum;
	logic signed [23:0] pre_reg [2];
	logic pre_valid_reg;
	logic [7:0] vol_target [2];
	logic post_valid [2];
	logic signed [23:0] post [2];
	logic signed [23:0] dly1_reg [2];
	logic signed [23:0] dly2_reg [2];
	logic signed [23:0] out_next [2];

	assign decimation_response_sel = filter_select_config_reg[dsp_cfg_pkg::DECIM_LSB +: 2];
	assign channel_sum_sel = filter_select_config_reg[dsp_cfg_pkg::SUM_LSB +: 2];
	assign highpass_sel = filter_select_config_reg[dsp_cfg_pkg::HP_LSB +: 2];
	assign volume_link = volume_biquad_config_reg[dsp_cfg_pkg::LINK_BIT];
	assign soft_step_off = volume_biquad_config_reg[dsp_cfg_pkg::SOFT_OFF_BIT];
	assign auto_gain_master_en = volume_biquad_config_reg[dsp_cfg_pkg::AGC_EN_BIT];
	assign auto_gain_target = auto_gain_level_config_reg[dsp_cfg_pkg::TARGET_LSB +: 4];
	assign auto_gain_ceiling = auto_gain_level_config_reg[dsp_cfg_pkg::CEIL_LSB +: 4];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// only writable bits take the bus value, so reserved read-only bits stay zero
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			filter_select_config_reg <= dsp_cfg_pkg::FILTER_SELECT_RESET;
			volume_biquad_config_reg <= dsp_cfg_pkg::VOLUME_BIQUAD_RESET;
			auto_gain_level_config_reg <= dsp_cfg_pkg::AUTO_GAIN_RESET;
		end else if (reg_wr_en_in) begin
			if (reg_addr_in == dsp_cfg_pkg::FILTER_SELECT_ADDR) begin
				filter_select_config_reg <= reg_wdata_in & dsp_cfg_pkg::FILTER_SELECT_WMASK;
			end else if (reg_addr_in == dsp_cfg_pkg::VOLUME_BIQUAD_ADDR) begin
				volume_biquad_config_reg <= reg_wdata_in & dsp_cfg_pkg::VOLUME_BIQUAD_WMASK;
			end else if (reg_addr_in == dsp_cfg_pkg::AUTO_GAIN_ADDR) begin
				auto_gain_level_config_reg <= reg_wdata_in & dsp_cfg_pkg::AUTO_GAIN_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_en_in) begin
			if (reg_addr_in == dsp_cfg_pkg::FILTER_SELECT_ADDR) begin
				reg_rdata_out <= filter_select_config_reg;
			end else if (reg_addr_in == dsp_cfg_pkg::VOLUME_BIQUAD_ADDR) begin
				reg_rdata_out <= volume_biquad_config_reg;
			end else if (reg_addr_in == dsp_cfg_pkg::AUTO_GAIN_ADDR) begin
				reg_rdata_out <= auto_gain_level_config_reg;
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// auto-gain and biquad settings
	// ----------------------------------------------------------------
	// reserved ceiling codes clamp to the top legal gain rather than wrap
	assign ceiling_code = (auto_gain_ceiling > dsp_cfg_pkg::CEIL_MAX_CODE) ?
		dsp_cfg_pkg::CEIL_MAX_CODE : auto_gain_ceiling;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			auto_gain_target_db_out <= 6'h00;
			auto_gain_ceiling_db_out <= 6'h00;
			agc_active_out <= 2'h0;
			biquad_count_out <= 2'h0;
		end else begin
			auto_gain_target_db_out <= 6'(dsp_cfg_pkg::TARGET_BASE_DB +
				dsp_cfg_pkg::TARGET_STEP_DB * int'(auto_gain_target));
			auto_gain_ceiling_db_out <= 6'(dsp_cfg_pkg::CEIL_STEP_DB *
				(int'(ceiling_code) + 1));
			// master enable is ANDed with each channel's own setup and its active bit
			agc_active_out <= {2{auto_gain_master_en}} & per_channel_setup_agc_in &
				channel_active_in;
			biquad_count_out <= volume_biquad_config_reg[dsp_cfg_pkg::BIQUAD_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------
	// channel summation
	// ----------------------------------------------------------------
	assign avg_sum = (25'(ch1_sample_in) + 25'(ch2_sample_in)) >>> 1;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			pre_valid_reg <= 1'b0;
			pre_reg[0] <= 24'sh000000;
			pre_reg[1] <= 24'sh000000;
		end else begin
			pre_valid_reg <= sample_valid_in;
			if (sample_valid_in && channel_sum_sel == dsp_cfg_pkg::SUM_AVERAGE) begin
				pre_reg[0] <= avg_sum[23:0];
				pre_reg[1] <= avg_sum[23:0];
			end else if (sample_valid_in) begin
				pre_reg[0] <= ch1_sample_in;
				pre_reg[1] <= ch2_sample_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// volume source selection
	// ----------------------------------------------------------------
	// with the link set channel 1 volume drives both, even while channel 1 is off
	assign vol_target[0] = first_channel_volume_in;
	assign vol_target[1] = volume_link ? first_channel_volume_in : second_channel_volume_in;

	// ----------------------------------------------------------------
	// per-channel high-pass, volume and latency line
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_chan
		channel_hp_volume u_chan (
			.clk_sys_in(clk_sys_in),
			.rstn_in(rstn_in),
			.highpass_sel_in(highpass_sel),
			.soft_step_off_in(soft_step_off),
			.vol_target_in(vol_target[c]),
			.valid_in(pre_valid_reg),
			.sample_in(pre_reg[c]),
			.valid_out(post_valid[c]),
			.sample_out(post[c])
		);

		always_ff @(posedge clk_sys_in) begin
			if (!rstn_in) begin
				dly1_reg[c] <= 24'sh000000;
				dly2_reg[c] <= 24'sh000000;
			end else if (post_valid[c]) begin
				dly1_reg[c] <= post[c];
				dly2_reg[c] <= dly1_reg[c];
			end
		end

		// code 3 is never programmed; it falls back to linear phase
		always_comb begin
			out_next[c] = dly2_reg[c];
			if (decimation_response_sel == dsp_cfg_pkg::DECIM_ULTRA) begin
				out_next[c] = post[c];
			end else if (decimation_response_sel == dsp_cfg_pkg::DECIM_LOW) begin
				out_next[c] = dly1_reg[c];
			end
			if (!channel_active_in[c]) begin
				out_next[c] = 24'sh000000;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			sample_valid_out <= 1'b0;
			ch1_sample_out <= 24'sh000000;
			ch2_sample_out <= 24'sh000000;
		end else begin
			sample_valid_out <= post_valid[0];
			if (post_valid[0]) begin
				ch1_sample_out <= out_next[0];
				ch2_sample_out <= out_next[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_reset_fields: assert property (@(posedge clk_sys_in)
		!rstn_in |=> decimation_response_sel == dsp_cfg_pkg::DECIM_LINEAR &&
		highpass_sel == dsp_cfg_pkg::HP_CUT_SLOW && channel_sum_sel == 2'h0)
		else $error("filter select fields wrong after reset");
	a_ultra_latency: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		post_valid[0] && channel_active_in[0] &&
		decimation_response_sel == dsp_cfg_pkg::DECIM_ULTRA |=>
		sample_valid_out && ch1_sample_out == $past(post[0]))
		else $error("ultra-low latency path delayed");
	a_sum_average: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		sample_valid_in && channel_sum_sel == dsp_cfg_pkg::SUM_AVERAGE |=>
		pre_reg[0] == pre_reg[1] && pre_reg[0] == $past(avg_sum[23:0]))
		else $error("summation did not give the average");
	a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		reg_rd_en_in && reg_addr_in == dsp_cfg_pkg::FILTER_SELECT_ADDR |=>
		reg_rdata_out[7:6] == 2'h0)
		else $error("reserved filter bits read nonzero");
	a_volume_own: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!volume_link |-> vol_target[1] == second_channel_volume_in)
		else $error("second channel lost its own volume");
	a_volume_link: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		volume_link |-> vol_target[1] == first_channel_volume_in &&
		vol_target[0] == first_channel_volume_in)
		else $error("linked volume not taken from channel 1");
	a_biquad_reset: assert property (@(posedge clk_sys_in)
		!rstn_in ##1 rstn_in |=> biquad_count_out == 2'h2)
		else $error("biquad count not two after reset");
	a_target_decode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		auto_gain_target == 4'hf ##1 auto_gain_target == 4'hf |->
		auto_gain_target_db_out == 6'h24)
		else $error("target code 15 not 36 dB");
	a_ceiling_decode: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		reg_wr_en_in && reg_addr_in == dsp_cfg_pkg::AUTO_GAIN_ADDR &&
		reg_wdata_in[3:0] == 4'hd |=> ##1 auto_gain_ceiling_db_out == 6'h2a)
		else $error("ceiling code 13 not 42 dB");
	c_sum_mode: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		sample_valid_out && channel_sum_sel == dsp_cfg_pkg::SUM_AVERAGE);
	c_linked: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		volume_link && !channel_active_in[0] && sample_valid_out);
	c_low_latency: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		decimation_response_sel == dsp_cfg_pkg::DECIM_LOW && sample_valid_out);
	c_fixed_highpass: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		highpass_sel == dsp_cfg_pkg::HP_CUT_MID && sample_valid_out);

	// ----------------------------------------------------------------
	// checks on the latency line and the derived settings
	// ----------------------------------------------------------------
	a_low_latency: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		post_valid[0] && channel_active_in[0] &&
		decimation_response_sel == dsp_cfg_pkg::DECIM_LOW |=>
		ch1_sample_out == $past(dly1_reg[0]))
		else $error("low latency path not one sample late");

	a_linear_latency: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		post_valid[0] && channel_active_in[0] &&
		decimation_response_sel == dsp_cfg_pkg::DECIM_LINEAR |=>
		ch1_sample_out == $past(dly2_reg[0]))
		else $error("linear path not two samples late");

	// an inactive channel keeps its slot but carries silence
	a_inactive_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		post_valid[0] && !channel_active_in[0] |=> ch1_sample_out == 24'sh000000)
		else $error("inactive channel not silent");

	a_sum_off: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		sample_valid_in && channel_sum_sel != dsp_cfg_pkg::SUM_AVERAGE |=>
		pre_reg[0] == $past(ch1_sample_in) && pre_reg[1] == $past(ch2_sample_in))
		else $error("channels mixed with summation off");

	a_link_reset: assert property (@(posedge clk_sys_in)
		!rstn_in |=> !volume_link && !soft_step_off && auto_gain_master_en)
		else $error("volume fields wrong after reset");

	a_biquad_follow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		$past(rstn_in) |->
		biquad_count_out == $past(volume_biquad_config_reg[dsp_cfg_pkg::BIQUAD_LSB +: 2]))
		else $error("biquad count lags its field");

	a_target_reset: assert property (@(posedge clk_sys_in)
		!rstn_in ##1 rstn_in |=> auto_gain_target_db_out == 6'h22)
		else $error("target not 34 dB after reset");

	a_ceiling_reset: assert property (@(posedge clk_sys_in)
		!rstn_in ##1 rstn_in |=> auto_gain_ceiling_db_out == 6'h18)
		else $error("ceiling not 24 dB after reset");

	a_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!reg_rd_en_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
endmodule // adc_dsp_chain_config

`default_nettype wire

// ---- verilog/dsp_cfg_pkg.sv ----
// constants for the recording-path dsp configuration block
//
// Contract
// - decimation response code 0 linear, 1 low latency, 2 ultra-low; resets 0; 3 never
// - summation code 1 outputs (ch1 + ch2) / 2; code 0 off; 2 and 3 reserved
// - highpass code 0 is a first-order iir that defaults to all-pass
// - highpass codes 1..3 cut at 0.00025, 0.002, 0.008 fs; reset code 1
// - link clear: each channel uses its own volume value
// - link set: all active channels use first channel volume, even if ch1 off
// - biquad count 0 none, 1..3 sections per channel; reset two
// - volume and mute ramp in soft steps unless soft-ramp-off is set
// - auto-gain target code n is -(6 + 2n) dB; resets to code 14
// - auto-gain ceiling code n is 3(n + 1) dB; resets to code 7
`default_nettype none

package dsp_cfg_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] FILTER_SELECT_ADDR = 8'h6b;
	localparam logic [7:0] VOLUME_BIQUAD_ADDR = 8'h6c;
	localparam logic [7:0] AUTO_GAIN_ADDR = 8'h70;
	localparam logic [7:0] FILTER_SELECT_RESET = 8'h01;
	localparam logic [7:0] VOLUME_BIQUAD_RESET = 8'h48;
	localparam logic [7:0] AUTO_GAIN_RESET = 8'he7;
	// writable bits; read-only reserved bits stay zero
	localparam logic [7:0] FILTER_SELECT_WMASK = 8'h3f;
	localparam logic [7:0] VOLUME_BIQUAD_WMASK = 8'hfc;
	localparam logic [7:0] AUTO_GAIN_WMASK = 8'hff;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DECIM_LSB = 4;
	localparam int SUM_LSB = 2;
	localparam int HP_LSB = 0;
	localparam int LINK_BIT = 7;
	localparam int BIQUAD_LSB = 5;
	localparam int SOFT_OFF_BIT = 4;
	localparam int AGC_EN_BIT = 3;
	localparam int TARGET_LSB = 4;
	localparam int CEIL_LSB = 0;

	// ----------------------------------------------------------------
	// field codes
	// ----------------------------------------------------------------
	localparam logic [1:0] DECIM_LINEAR = 2'h0;
	localparam logic [1:0] DECIM_LOW = 2'h1;
	localparam logic [1:0] DECIM_ULTRA = 2'h2;
	localparam logic [1:0] SUM_AVERAGE = 2'h1;
	localparam logic [1:0] HP_CUSTOM = 2'h0;
	localparam logic [1:0] HP_CUT_SLOW = 2'h1;
	localparam logic [1:0] HP_CUT_MID = 2'h2;
	localparam logic [3:0] CEIL_MAX_CODE = 4'hd;

	// ----------------------------------------------------------------
	// datapath sizing
	// ----------------------------------------------------------------
	localparam int SAMPLE_W = 24;
	// pole shifts approximate 2*pi*fc/fs for the three fixed cutoffs
	localparam int HP_SHIFT_SLOW = 9;
	localparam int HP_SHIFT_MID = 6;
	localparam int HP_SHIFT_FAST = 4;
	// extra output latency in samples per decimation response
	localparam int LAT_LINEAR = 2;
	localparam int LAT_LOW = 1;
	localparam int VOL_FRAC = 7;
	localparam int TARGET_BASE_DB = 6;
	localparam int TARGET_STEP_DB = 2;
	localparam int CEIL_STEP_DB = 3;
endpackage

`default_nettype wire

// ---- verilog/channel_hp_volume.sv ----
// one channel: high-pass section followed by stepped digital volume
`default_nettype none

module channel_hp_volume (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// settings
	input wire logic [1:0] highpass_sel_in,
	input wire logic soft_step_off_in,
	input wire logic [7:0] vol_target_in,
	// samples
	input wire logic valid_in,
	input wire logic signed [23:0] sample_in,
	output logic valid_out,
	output logic signed [23:0] sample_out
);
	logic signed [23:0] x_prev_reg;
	logic signed [23:0] hp_reg;
	logic hp_valid_reg;
	logic [7:0] vol_reg;
	logic signed [31:0] hp_next;
	logic signed [32:0] product;
	logic signed [32:0] scaled;
	int shift;

	function automatic logic signed [23:0] sat(input logic signed [31:0] v);
		if (v > 32'sh007fffff) begin
			return 24'sh7fffff;
		end else if (v < -32'sh00800000) begin
			return -24'sh800000;
		end
		return v[23:0];
	endfunction

	// ----------------------------------------------------------------
	// high-pass section
	// ----------------------------------------------------------------
	always_comb begin
		shift = dsp_cfg_pkg::HP_SHIFT_FAST;
		if (highpass_sel_in == dsp_cfg_pkg::HP_CUT_SLOW) begin
			shift = dsp_cfg_pkg::HP_SHIFT_SLOW;
		end else if (highpass_sel_in == dsp_cfg_pkg::HP_CUT_MID) begin
			shift = dsp_cfg_pkg::HP_SHIFT_MID;
		end
		// y = x - x_prev + y_prev * (1 - 2^-k)
		hp_next = 32'(sample_in) - 32'(x_prev_reg) + 32'(hp_reg) - 32'(hp_reg >>> shift);
		// custom section carries all-pass defaults; coefficients live elsewhere
		if (highpass_sel_in == dsp_cfg_pkg::HP_CUSTOM) begin
			hp_next = 32'(sample_in);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			x_prev_reg <= 24'sh000000;
			hp_reg <= 24'sh000000;
		end else if (valid_in) begin
			x_prev_reg <= sample_in;
			hp_reg <= sat(hp_next);
		end
	end

	// ----------------------------------------------------------------
	// volume, one code step per sample when ramping
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			vol_reg <= 8'h00;
		end else if (soft_step_off_in) begin
			vol_reg <= vol_target_in;
		end else if (valid_in && vol_reg < vol_target_in) begin
			vol_reg <= vol_reg + 8'h01;
		end else if (valid_in && vol_reg > vol_target_in) begin
			vol_reg <= vol_reg - 8'h01;
		end
	end

	assign product = hp_reg * $signed({1'b0, vol_reg});
	assign scaled = product >>> dsp_cfg_pkg::VOL_FRAC;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			hp_valid_reg <= 1'b0;
			valid_out <= 1'b0;
			sample_out <= 24'sh000000;
		end else begin
			hp_valid_reg <= valid_in;
			valid_out <= hp_valid_reg;
			if (hp_valid_reg) begin
				sample_out <= sat(scaled[31:0]);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_soft_ramp_step: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!soft_step_off_in && !$past(soft_step_off_in) |->
		(vol_reg - $past(vol_reg) <= 8'h01 || $past(vol_reg) - vol_reg <= 8'h01))
		else $error("volume jumped while ramping");
	a_hard_step: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		soft_step_off_in |=> vol_reg == $past(vol_target_in))
		else $error("volume did not jump with ramp off");
	c_ramp_up: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
		valid_in && !soft_step_off_in && vol_reg < vol_target_in);
endmodule // channel_hp_volume

`default_nettype wire

// ---- sim/host_ctrl_model.sv ----
// host software model that drives the configuration register port
`default_nettype none

module host_ctrl_model (
	// clock
	input wire logic clk_sys_in,
	// register port
	output logic [7:0] reg_addr_out,
	output logic reg_wr_en_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_rd_en_out,
	input wire logic [7:0] reg_rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr_out = 8'h00;
		reg_wr_en_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_en_out = 1'b0;
	end

	// ----------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------
	// raw skips the clean-up so that refused bits can be exercised on purpose
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input bit raw);
		logic [7:0] d;
		d = data;
		if (!raw && addr == dsp_cfg_pkg::FILTER_SELECT_ADDR) begin
			d[7:6] = 2'h0;
			if (d[5:4] == 2'h3) begin
				d[5:4] = 2'h0;
			end
		end
		if (!raw && addr == dsp_cfg_pkg::VOLUME_BIQUAD_ADDR) begin
			d[3] = 1'b1;
			d[2:0] = 3'h0;
		end
		if (!raw && addr == dsp_cfg_pkg::AUTO_GAIN_ADDR && d[3:0] > 4'hd) begin
			d[3:0] = 4'hd;
		end
		@(negedge clk_sys_in);
		reg_addr_out = addr;
		reg_wdata_out = d;
		reg_wr_en_out = 1'b1;
		@(negedge clk_sys_in);
		reg_wr_en_out = 1'b0;
		// stale data is not left on the bus to pass for a good write
		reg_wdata_out = ~d;
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clk_sys_in);
		reg_addr_out = addr;
		reg_rd_en_out = 1'b1;
		@(negedge clk_sys_in);
		reg_rd_en_out = 1'b0;
		@(negedge clk_sys_in);
		data = reg_rdata_in;
	endtask
endmodule // host_ctrl_model

`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the dsp configuration block
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	typedef struct {
		logic [7:0] addr;
		logic [7:0] wdata;
		bit raw;
		logic [7:0] rexp;
		logic [1:0] biq;
		logic [5:0] tgt;
		logic [5:0] ceil_db;
	} row_t;
	row_t rows [10] = '{
		'{8'h6b, 8'he5, 1'b1, 8'h25, 2'h2, 6'h22, 6'h18},
		'{8'h6c, 8'h0b, 1'b1, 8'h08, 2'h0, 6'h22, 6'h18},
		'{8'h6c, 8'h28, 1'b0, 8'h28, 2'h1, 6'h22, 6'h18},
		'{8'h6c, 8'h68, 1'b0, 8'h68, 2'h3, 6'h22, 6'h18},
		'{8'h6c, 8'h48, 1'b0, 8'h48, 2'h2, 6'h22, 6'h18},
		'{8'h70, 8'h00, 1'b0, 8'h00, 2'h2, 6'h06, 6'h03},
		'{8'h70, 8'h1d, 1'b0, 8'h1d, 2'h2, 6'h08, 6'h2a},
		'{8'h70, 8'h2c, 1'b0, 8'h2c, 2'h2, 6'h0a, 6'h27},
		'{8'h70, 8'hf1, 1'b0, 8'hf1, 2'h2, 6'h24, 6'h06},
		'{8'h71, 8'h55, 1'b0, 8'h00, 2'h2, 6'h24, 6'h06}};
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic reg_wr_en, reg_rd_en, sample_valid_out;
	logic valid_in = 1'b0;
	logic [7:0] vol1 = 8'h80;
	logic [7:0] vol2 = 8'h80;
	logic [1:0] active = 2'h3;
	logic [1:0] agc_req = 2'h0;
	logic signed [23:0] ch1_in = 24'h000000;
	logic signed [23:0] ch2_in = 24'h000000;
	logic signed [23:0] ch1_out, ch2_out, o1, o2, first;
	logic signed [23:0] last [4];
	logic [1:0] biq, agc_act;
	logic [5:0] tgt, ceil_db;
	int err_count = 0;
	int tests_run = 0;

	host_ctrl_model host (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr),
		.reg_wr_en_out(reg_wr_en), .reg_wdata_out(reg_wdata), .reg_rd_en_out(reg_rd_en),
		.reg_rdata_in(reg_rdata));

	adc_dsp_chain_config dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.reg_addr_in(reg_addr), .reg_wr_en_in(reg_wr_en), .reg_wdata_in(reg_wdata),
		.reg_rd_en_in(reg_rd_en), .reg_rdata_out(reg_rdata),
		.first_channel_volume_in(vol1), .second_channel_volume_in(vol2),
		.channel_active_in(active), .per_channel_setup_agc_in(agc_req),
		.sample_valid_in(valid_in), .ch1_sample_in(ch1_in), .ch2_sample_in(ch2_in),
		.sample_valid_out(sample_valid_out), .ch1_sample_out(ch1_out), .ch2_sample_out(ch2_out),
		.biquad_count_out(biq), .agc_active_out(agc_act),
		.auto_gain_target_db_out(tgt), .auto_gain_ceiling_db_out(ceil_db));

	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// ----------------------------------------------------------------
	// compare, stimulus and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cond(input logic got);
		tests_run++;
		if (got !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, 1'b1);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one strobe in, then wait a bounded time for the matching strobe out
	task automatic send(input logic [23:0] a, input logic [23:0] b);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		ch1_in = a;
		ch2_in = b;
		valid_in = 1'b1;
		@(negedge clk_sys_in);
		valid_in = 1'b0;
		ch1_in = ~a;
		ch2_in = ~b;
		while (sample_valid_out !== 1'b1 && n < 12) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		chk_cond(n < 12);
		o1 = ch1_out;
		o2 = ch2_out;
	endtask

	task automatic reset_check;
		@(negedge clk_sys_in);
		rstn_in = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		host.read_reg(8'h6b, rd);
		chk_reg(rd, 8'h01);
		host.read_reg(8'h6c, rd);
		chk_reg(rd, 8'h48);
		host.read_reg(8'h70, rd);
		chk_reg(rd, 8'he7);
		chk_reg({6'h00, biq}, 8'h02);
		chk_reg({2'h0, tgt}, 8'h22);
		chk_reg({2'h0, ceil_db}, 8'h18);
		$display("test reset done");
	endtask

	// ----------------------------------------------------------------
	// watchdog: the whole run needs well under 5000 cycles
	// ----------------------------------------------------------------
	initial begin
		#200000;
		err_count++;
		$display("watchdog expired");
		give_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_check();
		for (int i = 0; i < 10; i++) begin
			host.write_reg(rows[i].addr, rows[i].wdata, rows[i].raw);
			host.read_reg(rows[i].addr, rd);
			chk_reg(rd, rows[i].rexp);
			chk_reg({6'h00, biq}, {6'h00, rows[i].biq});
			chk_reg({2'h0, tgt}, {2'h0, rows[i].tgt});
			chk_reg({2'h0, ceil_db}, {2'h0, rows[i].ceil_db});
		end
		$display("test register rows done");
		// volume still ramps from zero, so the first sample is nearly silent
		host.write_reg(8'h6b, 8'h20, 1'b0);
		host.write_reg(8'h6c, 8'h48, 1'b0);
		send(24'h010000, 24'h010000);
		chk_cond(o1 < 24'sh000800);
		host.write_reg(8'h6c, 8'h58, 1'b0);
		send(24'h010000, 24'h020000);
		chk_smp(o1, 24'h010000);
		chk_smp(o2, 24'h020000);
		@(negedge clk_sys_in);
		vol2 = 8'h40;
		send(24'h010000, 24'h010000);
		chk_smp(o2, 24'h008000);
		host.write_reg(8'h6c, 8'hd8, 1'b0);
		send(24'h010000, 24'h010000);
		chk_smp(o2, 24'h010000);
		@(negedge clk_sys_in);
		active = 2'h2;
		send(24'h010000, 24'h010000);
		chk_smp(o1, 24'h000000);
		chk_smp(o2, 24'h010000);
		$display("test volume done");
		@(negedge clk_sys_in);
		active = 2'h3;
		host.write_reg(8'h6b, 8'h24, 1'b0);
		send(24'h000100, 24'hfffd00);
		chk_smp(o1, 24'hffff00);
		chk_smp(o2, 24'hffff00);
		$display("test summation done");
		for (int c = 0; c < 3; c++) begin
			host.write_reg(8'h6b, 8'(c << 4), 1'b0);
			for (int k = 0; k < 3; k++) begin
				send(24'(24'h011000 * (k + 1)), 24'h000000);
			end
			chk_smp(o1, 24'(24'h011000 * (c + 1)));
		end
		$display("test decimation done");
		// a higher cutoff must bleed off a dc level faster
		for (int c = 1; c < 4; c++) begin
			host.write_reg(8'h6b, 8'h20, 1'b0);
			send(24'h000000, 24'h000000);
			host.write_reg(8'h6b, 8'(8'h20 + c), 1'b0);
			send(24'h100000, 24'h100000);
			first = o1;
			repeat (60) send(24'h100000, 24'h100000);
			chk_cond(o1 < first);
			last[c] = o1;
		end
		chk_cond(last[1] > last[2] && last[2] > last[3]);
		$display("test highpass done");
		@(negedge clk_sys_in);
		agc_req = 2'h1;
		repeat (2) @(negedge clk_sys_in);
		chk_reg({6'h00, agc_act}, 8'h01);
		active = 2'h2;
		agc_req = 2'h3;
		repeat (2) @(negedge clk_sys_in);
		chk_reg({6'h00, agc_act}, 8'h02);
		$display("test auto gain done");
		reset_check();
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
